// file: bench/dest_addr_forwarding_table_monitor.sv
// Checker on the table's lookup result port
`timescale 1ns/1ps
`default_nettype none
module dest_addr_forwarding_table_monitor (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic lookupValid,
	input wire logic resultValid,
	input wire logic resultHit,
	input wire logic forwardToCpu,
	input wire logic forwardCrossPort,
	input wire logic hostQueuePriority,
	input wire logic resultDrop,
	input wire logic [3:0] resultEntry
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_result_one_cycle: assert property
		(lookupValid |=> resultValid) else $error("no result");
	a_no_stray_result: assert property
		(!lookupValid |=> !resultValid) else $error("stray result");
	a_drop_only: assert property
		(resultDrop |-> !forwardToCpu && !forwardCrossPort) else $error("drop");
	a_prio_with_cpu: assert property
		(hostQueuePriority |-> forwardToCpu) else $error("prio");
	a_cpu_on_hit: assert property
		(forwardToCpu |-> resultHit) else $error("cpu");
	a_hit_has_action: assert property
		(resultHit |-> forwardToCpu | forwardCrossPort | resultDrop)
		else $error("no action");
	a_miss_entry_zero: assert property
		(resultValid && !resultHit |-> resultEntry == 4'h0) else $error("entry");
	a_idle_quiet: assert property
		(!resultValid |-> !resultHit && !resultDrop) else $error("idle");
	cover property (resultDrop);
	cover property (hostQueuePriority);
	cover property (resultValid && !resultHit);
	cover property (forwardCrossPort && forwardToCpu);
endmodule
bind dest_addr_forwarding_table dest_addr_forwarding_table_monitor mon (
	.core_clk(core_clk),
	.rstn(rstn),
	.lookupValid(lookupValid),
	.resultValid(resultValid),
	.resultHit(resultHit),
	.forwardToCpu(forwardToCpu),
	.forwardCrossPort(forwardCrossPort),
	.hostQueuePriority(hostQueuePriority),
	.resultDrop(resultDrop),
	.resultEntry(resultEntry)
);
`default_nettype wire

// file: bench/host_model.sv
// Host model that programs table entries
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic core_clk,
	output logic regWrite,
	output logic [7:0] regAddr,
	output logic [31:0] regWdata);
	initial {regWrite, regAddr, regWdata} = {1'b0, 8'h70, 32'h0};
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) #1;
		{regWrite, regAddr, regWdata} = {1'b1, a, d};
		@(posedge core_clk) #1;
		{regWrite, regWdata} = {1'b0, ~d};
	endtask
	// Upper first so the pair commits whole; no reassigned high queue here
	task automatic prog(input logic [7:0] a, input logic [31:0] u, l);
		wr(a, u);
		wr(a + 8'h01, l);
	endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the forwarding table
`timescale 1ns/1ps
`default_nettype none
module tb;
	import da_filter_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, lookupValid = 1'b0, lookupPort = 1'b0;
	logic regWrite, resultValid, resultHit, forwardToCpu, forwardCrossPort;
	logic hostQueuePriority, resultDrop;
	logic [3:0] resultEntry;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic [47:0] lookupDa = 48'h0;
	int num_errors = 0, n_compared = 0;
	// Port, destination, then valid hit entry cpu cross prio drop
	logic [63:0] rows [7] = '{64'h0_9999222233AB_308, 64'h0_AAAA00000001_32E,
		64'h1_AAAA00000001_32E, 64'h0_BBBB00000001_334, 64'h1_BBBB00000001_341,
		64'h1_CCCC00000002_35E, 64'h0_DDDD00000001_200};
	always #4 core_clk = ~core_clk;
	host_model hm (.*);
	dest_addr_forwarding_table DUT (.*);
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		num_errors += int'(g !== e);
		if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
	endtask
	task automatic lk(input logic [63:0] r);
		@(posedge core_clk) #1;
		{lookupValid, lookupPort, lookupDa} = {1'b1, r[60:12]};
		@(posedge core_clk) #1;
		lookupValid = 1'b0;
		chk({22'h0, resultValid, resultHit, resultEntry, forwardToCpu,
			forwardCrossPort, hostQueuePriority, resultDrop}, {22'h0, r[9:0]});
	endtask
	task automatic wrap_up;
		$display("errors %0d of %0d compares", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		#1 chk({31'h0, resultValid}, 32'h0);
		chk(regRdata, MASK_UPPER_RESET);
		rstn = 1'b1;
		hm.prog(MASK_BASE, 32'h0, 32'hFFFF_FF00);
		hm.prog(FILT_BASE, 32'h4001_1111, 32'h2222_3300);
		hm.prog(8'h54, 32'hC00B_AAAA, 32'h1);
		hm.prog(8'h56, 32'h4002_BBBB, 32'h1);
		hm.prog(8'h58, 32'h8000_BBBB, 32'h1);
		hm.wr(8'h5A, 32'hFFFF_CCCC);
		chk(regRdata, 32'hFFFF_CCCC & UPPER_WRITABLE);
		hm.wr(8'h5B, 32'h2);
		chk(regRdata, 32'h2);
		foreach (rows[i]) lk(rows[i]);
		hm.wr(8'h5C, 32'h4001_EEEE);
		lk(64'h0_EEEE00000000_200);
		hm.wr(8'h5D, 32'h0);
		lk(64'h0_EEEE00000000_368);
		wrap_up();
	end
	initial #5000 begin
		num_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire

// file: logic/da_filter_pkg.sv
// Constants for the destination-address forwarding table
package da_filter_pkg;
	localparam int ENTRY_COUNT = 16;
	localparam int MASK_COUNT = 2;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 4;
	localparam logic [7:0] FILT_BASE = 8'h50;
	localparam logic [7:0] FILT_LAST = 8'h6F;
	localparam logic [7:0] MASK_BASE = 8'h70;
	localparam logic [7:0] MASK_LAST = 8'h73;
	localparam int SECOND_INGRESS_BIT = 31;
	localparam int FIRST_INGRESS_BIT = 30;
	localparam int HOST_QUEUE_PRIORITY_BIT = 19;
	localparam int CROSS_PORT_BIT = 17;
	localparam int TO_CPU_BIT = 16;
	localparam logic [31:0] UPPER_WRITABLE = 32'hC00BFFFF;
	localparam logic [31:0] MASK_UPPER_WRITABLE = 32'h0000FFFF;
	localparam logic [31:0] FILT_RESET = 32'h00000000;
	localparam logic [31:0] MASK_UPPER_RESET = 32'h0000FFFF;
	localparam logic [31:0] MASK_LOWER_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] READ_ZERO = 32'h00000000;
	localparam logic [47:0] FULL_MASK = 48'hFFFFFFFFFFFF;
endpackage

// file: logic/dest_addr_forwarding_table.sv
// Destination-address filter and forwarding-rule table
`timescale 1ns/1ps
`default_nettype none
module dest_addr_forwarding_table (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [da_filter_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	input wire logic lookupValid,
	input wire logic lookupPort,
	input wire logic [47:0] lookupDa,
	output logic resultValid,
	output logic resultHit,
	output logic [da_filter_pkg::IDX_W-1:0] resultEntry,
	output logic forwardToCpu,
	output logic forwardCrossPort,
	output logic hostQueuePriority,
	output logic resultDrop
);
	import da_filter_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register decode
	wire [31:0] upperShadow [ENTRY_COUNT];
	wire [31:0] lowerShadow [ENTRY_COUNT];
	wire [31:0] upperLive [ENTRY_COUNT];
	wire [31:0] maskUpShadow [MASK_COUNT];
	wire [31:0] maskLow [MASK_COUNT];

	wire inFilt = (regAddr >= FILT_BASE) && (regAddr <= FILT_LAST);
	wire inMask = (regAddr >= MASK_BASE) && (regAddr <= MASK_LAST);
	wire [7:0] filtOff = regAddr - FILT_BASE;
	wire [7:0] maskOff = regAddr - MASK_BASE;
	wire [IDX_W-1:0] filtIdx = filtOff[IDX_W:1];
	wire maskIdx = maskOff[1];
	wire isLowerWord = regAddr[0];
	wire filtWrite = regWrite && inFilt;
	wire maskWrite = regWrite && inMask;
	// Reserved bits are dropped on the way in, so they always read zero
	wire [31:0] upperWdata = regWdata & UPPER_WRITABLE;
	wire [31:0] maskUpWdata = regWdata & MASK_UPPER_WRITABLE;

	// Upper-word reads show the staged words, not what lookups use yet; lower-word reads show the live words
	wire [31:0] filtRead = isLowerWord ? lowerShadow[filtIdx] :
		upperShadow[filtIdx];
	wire [31:0] maskRead = isLowerWord ? maskLow[maskIdx] :
		maskUpShadow[maskIdx];
	// Unmapped words read as zero
	assign regRdata = inFilt ? filtRead : inMask ? maskRead : READ_ZERO;

	////////////////////////////////////////////////////////////////////////
	// Per-entry storage and compare
	// Upper words stage until the lower word lands, so a lookup never
	// pairs new rules with an old address.
	wire [ENTRY_COUNT-1:0] entryHit;
	genvar g;
	generate
		for (g = 0; g < ENTRY_COUNT; g++) begin : gEntry
			wire selEntry = filtIdx == IDX_W'(g);
			wire wrUpper = filtWrite && selEntry && !isLowerWord;
			wire wrLower = filtWrite && selEntry && isLowerWord;
			logic [31:0] upperStage;
			logic [31:0] upperCommitted;
			logic [31:0] lowerWord;
			wire [47:0] entryAddr;
			wire [47:0] entryMask;
			wire [47:0] addrDiff;
			wire [47:0] maskedDiff;

			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					upperStage <= FILT_RESET;
				end else if (wrUpper) begin
					upperStage <= upperWdata;
				end
			end

			// Lower write commits the staged rules on the same edge
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					lowerWord <= FILT_RESET;
					upperCommitted <= FILT_RESET;
				end else if (wrLower) begin
					lowerWord <= regWdata;
					upperCommitted <= upperStage;
				end
			end

			assign upperShadow[g] = upperStage;
			assign lowerShadow[g] = lowerWord;
			assign upperLive[g] = upperCommitted;
			assign entryAddr = {upperCommitted[15:0], lowerWord};

			// Only the first entries own a mask slot
			if (g < MASK_COUNT) begin : gMasked
				wire selMask = maskIdx == 1'(g);
				wire wrMaskUp = maskWrite && selMask && !isLowerWord;
				wire wrMaskLow = maskWrite && selMask && isLowerWord;
				logic [31:0] maskUpStage;
				logic [31:0] maskUpCommitted;
				logic [31:0] maskLowWord;
				always_ff @(posedge core_clk) begin
					if (!rstn) begin
						maskUpStage <= MASK_UPPER_RESET;
					end else if (wrMaskUp) begin
						maskUpStage <= maskUpWdata;
					end
				end
				always_ff @(posedge core_clk) begin
					if (!rstn) begin
						maskUpCommitted <= MASK_UPPER_RESET;
						maskLowWord <= MASK_LOWER_RESET;
					end else if (wrMaskLow) begin
						maskUpCommitted <= maskUpStage;
						maskLowWord <= regWdata;
					end
				end
				assign maskUpShadow[g] = maskUpStage;
				assign maskLow[g] = maskLowWord;
				assign entryMask = {maskUpCommitted[15:0], maskLowWord};
			end else begin : gExact
				// No mask slot: every address bit must agree
				assign entryMask = FULL_MASK;
			end

			wire appliesFirst = upperCommitted[FIRST_INGRESS_BIT];
			wire appliesSecond = upperCommitted[SECOND_INGRESS_BIT];
			wire applies = lookupPort ? appliesSecond : appliesFirst;
			assign addrDiff = lookupDa ^ entryAddr;
			assign maskedDiff = addrDiff & entryMask;
			assign entryHit[g] = applies && (maskedDiff == '0);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Lowest index wins when several entries match
	logic [IDX_W-1:0] firstHit;
	always_comb begin
		firstHit = '0;
		for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
			if (entryHit[i]) begin
				firstHit = IDX_W'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Forwarding decision of the winning entry
	wire anyHit = |entryHit;
	wire [31:0] hitRules = upperLive[firstHit];
	wire ruleCpu = hitRules[TO_CPU_BIT];
	wire ruleCross = hitRules[CROSS_PORT_BIT];
	wire rulePri = hitRules[HOST_QUEUE_PRIORITY_BIT];
	wire hitCpu = anyHit && ruleCpu;
	wire hitCross = anyHit && ruleCross;
	wire hitDrop = anyHit && !ruleCpu && !ruleCross;
	// Priority only meaningful toward the host; gated here by hitCpu
	wire hitPri = hitCpu && rulePri;

	// All result outputs rest at zero between requests
	wire next_resultHit = lookupValid && anyHit;
	wire [IDX_W-1:0] next_resultEntry = lookupValid ? firstHit : '0;
	wire next_forwardToCpu = lookupValid && hitCpu;
	wire next_forwardCrossPort = lookupValid && hitCross;
	wire next_hostQueuePriority = lookupValid && hitPri;
	wire next_resultDrop = lookupValid && hitDrop;

	////////////////////////////////////////////////////////////////////////
	// Registered lookup result, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			resultValid <= 1'b0;
			resultHit <= 1'b0;
			resultEntry <= '0;
		end else begin
			resultValid <= lookupValid;
			resultHit <= next_resultHit;
			resultEntry <= next_resultEntry;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			forwardToCpu <= 1'b0;
			forwardCrossPort <= 1'b0;
		end else begin
			forwardToCpu <= next_forwardToCpu;
			forwardCrossPort <= next_forwardCrossPort;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hostQueuePriority <= 1'b0;
			resultDrop <= 1'b0;
		end else begin
			hostQueuePriority <= next_hostQueuePriority;
			resultDrop <= next_resultDrop;
		end
	end
endmodule
`default_nettype wire
